// ---- hdl/cam_pkg.sv ----
// Package: register map, field layout, constants and types of the cam block
package cam_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_OPMODE = 8'h04;
    localparam logic [7:0] A_FUNC   = 8'h08;
    localparam logic [7:0] A_INIT   = 8'h0C;
    localparam logic [7:0] A_CAMSEL = 8'h10;
    localparam logic [7:0] A_CDNO   = 8'h14;
    localparam logic [7:0] A_CYCLEN = 8'h18;
    localparam logic [7:0] A_STROKE = 8'h1C;
    localparam logic [7:0] A_NCOORD = 8'h20;
    localparam logic [7:0] A_PROBE  = 8'h24;
    localparam logic [7:0] A_TADDR  = 8'h28;
    localparam logic [7:0] A_TTMP   = 8'h2C;
    localparam logic [7:0] A_TPERM  = 8'h30;
    localparam logic [7:0] A_STAT   = 8'h34;
    localparam logic [7:0] A_FEED   = 8'h38;
    localparam logic [7:0] A_CPOS   = 8'h3C;
    // ****************************************
    // Values, field positions, reset values
    // ****************************************
    localparam logic [15:0] INIT_KEY    = 16'h5010;
    localparam logic [3:0]  OPMODE_PT   = 4'h6;
    localparam int          FUNC_CAM    = 0;
    localparam int          ST_LOADED   = 0;
    localparam int          ST_WARN     = 1;
    localparam int          ST_RUN      = 2;
    localparam int          ST_CAM      = 4;
    localparam logic [11:0] RES_MIN     = 12'h100;
    localparam int          RATIO_SH    = 16;
    localparam logic [31:0] RATIO_FULL  = 32'h0001_0000;
    localparam logic [10:0] TBL_LAST    = 11'h7FF;
    localparam logic [31:0] CYCLEN_RST  = 32'h0000_0800;
    localparam logic [10:0] NCOORD_RST  = 11'h002;
    localparam logic [5:0]  DIV_STEPS   = 6'h2F;
    localparam int          DIV_W       = 48;

    typedef struct packed {
        logic       servo_on;
        logic       fmt_coord;
        logic [1:0] res;
        logic       use_cd;
        logic       cmd;
        logic       src_servo;
    } cam_ctrl_t;

    localparam cam_ctrl_t CTRL_RST = 7'h00;

    typedef struct packed {
        logic       wr;
        logic [7:0] a;
    } ahb_ap_t;

    typedef enum {LD_COPY, LD_RUN, LD_ERASE} ld_state_t;
endpackage : cam_pkg

// ---- hdl/cam_profile_store_select.sv ----
// Cam table storage, selection, input source and feed position logic
// Function
// - Quadrature A/B pulses from the sync encoder, up to 4 Mpulses/s, drive the axis.
// - Probe edge computes a correction and adds it to the feed position output.
// - Main-shaft select picks encoder axis or servo input axis as command.
// - Cam resolution is one of 256, 512, 1024 or 2048 divisions.
// - A cycle length register sets input travel of one cam cycle.
// - Stroke amount is the output displacement for a 100% ratio.
// - Cam runs only in point-table mode with cam function enabled.
// - Active table comes from cam number word or control data entry 49.
// - At power-up all tables copy from storage to working RAM.
// - Temporary write goes to RAM only, works at once, lost at power-off.
// - Permanent write goes to storage only, active after next power cycle.
// - With miswrite warning, writing 5010 to init parameter erases cam data.
// - Ratio table: equal steps per cycle, one ratio entry per step.
// - Coordinate table: two or more input/output pairs within one cycle.
// - Output is standard position plus stroke times interpolated ratio; coordinate tables add the interpolated output directly.
// - Cam 0 is built-in linear to 100%; 1 to 8 are user tables.
// - Cam number and stroke take effect on command bit rising.
// - Standard position updates whenever the cycle passes point zero.
module cam_profile_store_select (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        probe_in,
    input  wire logic        servo_step,
    input  wire logic        servo_dir,
    output logic [31:0]      feed_pos,
    output logic             cam_active
);
    import cam_pkg::*;

    // ****************************************
    // Registers and storage
    // ****************************************
    cam_ctrl_t          ctrl_reg;
    ahb_ap_t            ap_reg;
    ld_state_t          ld_state_reg;
    logic [3:0]         opmode_reg, camsel_reg, cdno_reg, act_cam_reg;
    logic [15:0]        func_reg;
    logic [31:0]        cyclen_reg, stroke_reg, act_stroke_reg, probe_ref_reg;
    logic [10:0]        ncoord_reg, taddr_reg, ld_idx_reg, idx_reg;
    logic [9:0]         seg_reg;
    logic [31:0]        pos_reg, acc_reg, rd_next;
    logic signed [31:0] std_reg, corr_reg, base_l_reg;
    logic               warn_reg, cmd_q_reg, run_reg;
    logic signed [31:0] ram [0:2047];
    // Blank storage reads zero at first power-up, so the copy never spreads unknowns
    logic signed [31:0] nv  [0:2047] = '{default: '0};

    // Storage has no reset: hresetn stands for power-up, nv keeps its words
    logic ap, we, wr_ok, run, coord, cmd_rise;
    assign ap       = hsel & htrans[1] & hready & (hsize == 3'b010);
    assign we       = ap_reg.wr;
    assign wr_ok    = !ctrl_reg.servo_on && ld_state_reg == LD_RUN;
    assign run      = (ld_state_reg == LD_RUN) && (opmode_reg == OPMODE_PT)
                      && func_reg[FUNC_CAM];
    assign cmd_rise = ctrl_reg.cmd & ~cmd_q_reg;

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_reg    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
        end else begin
            ap_reg.wr <= ap & hwrite;
            ap_reg.a  <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= (ap & !hwrite) ? rd_next : 32'h0000_0000;
        end
    end

    always_comb begin
        case (haddr[7:0])
            A_CTRL:   rd_next = {25'h0, ctrl_reg};
            A_OPMODE: rd_next = {28'h0, opmode_reg};
            A_FUNC:   rd_next = {16'h0, func_reg};
            A_CAMSEL: rd_next = {28'h0, camsel_reg};
            A_CDNO:   rd_next = {28'h0, cdno_reg};
            A_CYCLEN: rd_next = cyclen_reg;
            A_STROKE: rd_next = stroke_reg;
            A_NCOORD: rd_next = {21'h0, ncoord_reg};
            A_PROBE:  rd_next = probe_ref_reg;
            A_TADDR:  rd_next = {21'h0, taddr_reg};
            A_STAT:   rd_next = {24'h0, act_cam_reg, 1'b0, run_reg, warn_reg,
                                 ld_state_reg == LD_RUN};
            A_FEED:   rd_next = feed_pos;
            A_CPOS:   rd_next = pos_reg;
            default:  rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg      <= CTRL_RST;
            opmode_reg    <= '0;
            func_reg      <= '0;
            camsel_reg    <= '0;
            cdno_reg      <= '0;
            cyclen_reg    <= CYCLEN_RST;
            stroke_reg    <= '0;
            ncoord_reg    <= NCOORD_RST;
            probe_ref_reg <= '0;
            taddr_reg     <= '0;
        end else if (we) begin
            case (ap_reg.a)
                A_CTRL:   ctrl_reg      <= hwdata[6:0];
                A_OPMODE: opmode_reg    <= hwdata[3:0];
                A_FUNC:   func_reg      <= hwdata[15:0];
                A_CAMSEL: camsel_reg    <= hwdata[3:0];
                A_CDNO:   cdno_reg      <= hwdata[3:0];
                A_CYCLEN: cyclen_reg    <= hwdata;
                A_STROKE: stroke_reg    <= hwdata;
                A_NCOORD: ncoord_reg    <= hwdata[10:0];
                A_PROBE:  probe_ref_reg <= hwdata;
                A_TADDR:  taddr_reg     <= hwdata[10:0];
                A_TTMP,
                A_TPERM:  taddr_reg     <= taddr_reg + 11'h001;
                default:  ;
            endcase
        end
    end

    // ****************************************
    // Command latch, warning, loader
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_q_reg      <= 1'b0;
            act_cam_reg    <= '0;
            act_stroke_reg <= '0;
        end else begin
            cmd_q_reg <= ctrl_reg.cmd;
            if (cmd_rise) begin
                act_cam_reg    <= ctrl_reg.use_cd ? cdno_reg : camsel_reg;
                act_stroke_reg <= stroke_reg;
            end
        end
    end

    logic tbl_wr, init_hit;
    assign tbl_wr   = we && (ap_reg.a == A_TTMP || ap_reg.a == A_TPERM);
    assign init_hit = we && ap_reg.a == A_INIT && warn_reg && hwdata[15:0] == INIT_KEY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld_state_reg <= LD_COPY;
            ld_idx_reg   <= '0;
            warn_reg     <= 1'b0;
        end else begin
            if (tbl_wr && !wr_ok)
                warn_reg <= 1'b1;
            else if (init_hit)
                warn_reg <= 1'b0;
            case (ld_state_reg)
                LD_COPY, LD_ERASE: begin
                    ld_idx_reg <= ld_idx_reg + 11'h001;
                    if (ld_idx_reg == TBL_LAST)
                        ld_state_reg <= LD_RUN;
                end
                LD_RUN: begin
                    ld_idx_reg <= '0;
                    if (init_hit)
                        ld_state_reg <= LD_ERASE;
                end
                default: ld_state_reg <= LD_RUN;
            endcase
        end
    end

    // Temporary writes hit only RAM, permanent only storage
    always_ff @(posedge hclk) begin
        if (ld_state_reg == LD_COPY)
            ram[ld_idx_reg] <= nv[ld_idx_reg];
        else if (ld_state_reg == LD_ERASE)
            ram[ld_idx_reg] <= '0;
        else if (we && ap_reg.a == A_TTMP && wr_ok)
            ram[taddr_reg] <= hwdata;
    end

    always_ff @(posedge hclk) begin
        if (ld_state_reg == LD_ERASE)
            nv[ld_idx_reg] <= '0;
        else if (we && ap_reg.a == A_TPERM && wr_ok)
            nv[taddr_reg] <= hwdata;
    end

    // ****************************************
    // Input axis: sync, decode, source select
    // ****************************************
    logic [2:0] sa, sb, sp;
    logic       a_st, b_st, a_pv, b_pv, p_st, p_pv;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {sa, sb, sp}             <= '0;
            {a_st, b_st, a_pv, b_pv} <= '0;
            {p_st, p_pv}             <= '0;
        end else begin
            sa <= {sa[1:0], enc_a};
            sb <= {sb[1:0], enc_b};
            sp <= {sp[1:0], probe_in};
            if (sa[1] == sa[2]) a_st <= sa[2];
            if (sb[1] == sb[2]) b_st <= sb[2];
            if (sp[1] == sp[2]) p_st <= sp[2];
            {a_pv, b_pv, p_pv} <= {a_st, b_st, p_st};
        end
    end

    // x4 decode; a double change is a lost count and is dropped
    logic enc_step, enc_fwd, step_en, fwd, wrap_f, wrap_b;
    assign enc_step = (a_st ^ a_pv) ^ (b_st ^ b_pv);
    assign enc_fwd  = ~(a_pv ^ b_st);
    assign step_en  = run && (ctrl_reg.src_servo ? servo_step : enc_step);
    assign fwd      = ctrl_reg.src_servo ? servo_dir : enc_fwd;
    assign wrap_f   = step_en && fwd && pos_reg >= cyclen_reg - 32'h0000_0001;
    assign wrap_b   = step_en && !fwd && pos_reg == '0;

    // ****************************************
    // Cycle position and table index
    // ****************************************
    logic [11:0] res;
    logic [31:0] res32;
    assign res   = RES_MIN << ctrl_reg.res;
    assign res32 = {20'h0, res};

    // Index tracks pos*res/len without a divider; assumes len >= res
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_reg <= '0;
            idx_reg <= '0;
            acc_reg <= '0;
        end else if (wrap_f) begin
            {pos_reg, idx_reg, acc_reg} <= '0;
        end else if (wrap_b) begin
            pos_reg <= cyclen_reg - 32'h0000_0001;
            idx_reg <= 11'(res - 12'h001);
            acc_reg <= cyclen_reg - res32;
        end else if (step_en && fwd) begin
            pos_reg <= pos_reg + 32'h0000_0001;
            if (acc_reg + res32 >= cyclen_reg) begin
                acc_reg <= acc_reg + res32 - cyclen_reg;
                idx_reg <= idx_reg + 11'h001;
            end else
                acc_reg <= acc_reg + res32;
        end else if (step_en) begin
            pos_reg <= pos_reg - 32'h0000_0001;
            if (acc_reg < res32) begin
                acc_reg <= acc_reg + cyclen_reg - res32;
                idx_reg <= idx_reg - 11'h001;
            end else
                acc_reg <= acc_reg - res32;
        end
    end

    // ****************************************
    // Table lookup
    // ****************************************
    logic [10:0]        base, ai, ac;
    logic               last;
    logic signed [31:0] r0, r1, r_last, x0, y0, x1, y1, y_end;
    assign coord = ctrl_reg.fmt_coord && act_cam_reg != '0;
    assign base  = 11'(({8'h0, act_cam_reg} - 12'h001) * res);
    assign ai    = base + idx_reg;
    assign ac    = base + {seg_reg, 1'b0};
    assign last  = {1'b0, idx_reg} == res - 12'h001;
    assign x0    = ram[ac];
    assign y0    = ram[ac + 11'h001];
    assign x1    = ram[ac + 11'h002];
    assign y1    = ram[ac + 11'h003];
    assign y_end = ram[base + {ncoord_reg[9:0], 1'b0} - 11'h001] - ram[base + 11'h001];

    // Cam 0 is a straight line reaching full ratio after the last point
    always_comb begin
        if (act_cam_reg == '0) begin
            r0     = 32'({idx_reg, 16'h0000} >> (8 + ctrl_reg.res));
            r1     = 32'({idx_reg + 11'h001, 16'h0000} >> (8 + ctrl_reg.res));
            r_last = RATIO_FULL;
        end else begin
            r0     = ram[ai];
            r1     = last ? ram[ai] : ram[ai + 11'h001];
            r_last = ram[base + 11'(res - 12'h001)];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            seg_reg <= '0;
        else if (wrap_f || wrap_b)
            seg_reg <= '0;
        else if (pos_reg >= $unsigned(x1) && {1'b0, seg_reg} + 11'h002 < ncoord_reg)
            seg_reg <= seg_reg + 10'h001;
        else if (pos_reg < $unsigned(x0) && seg_reg != '0)
            seg_reg <= seg_reg - 10'h001;
    end

    // ****************************************
    // Interpolation divider and feed output
    // ****************************************
    logic signed [31:0] delta;
    logic [31:0]        frac, dmag, den;
    logic [63:0]        prod;
    logic [DIV_W-1:0]   quo_reg;
    logic [31:0]        rem_reg, den_reg;
    logic [32:0]        t;
    logic [5:0]         cnt_reg;
    logic               busy_reg, neg_reg, coord_l_reg;
    assign delta = coord ? y1 - y0 : r1 - r0;
    assign frac  = coord ? pos_reg - x0 : acc_reg;
    assign den   = coord ? ((x1 == x0) ? 32'h0000_0001 : x1 - x0) : cyclen_reg;
    assign dmag  = delta[31] ? -delta : delta;
    assign prod  = {32'h0, frac} * {32'h0, dmag};
    assign t     = {rem_reg, quo_reg[DIV_W-1]};

    // Serial divide costs 49 cycles per update (48 steps plus a load); output lags fast inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg    <= 1'b0;
            cnt_reg     <= '0;
            quo_reg     <= '0;
            rem_reg     <= '0;
            den_reg     <= 32'h0000_0001;
            neg_reg     <= 1'b0;
            coord_l_reg <= 1'b0;
            base_l_reg  <= '0;
        end else if (!busy_reg) begin
            busy_reg    <= 1'b1;
            cnt_reg     <= DIV_STEPS;
            quo_reg     <= prod[DIV_W-1:0];
            rem_reg     <= '0;
            den_reg     <= den;
            neg_reg     <= delta[31];
            coord_l_reg <= coord;
            base_l_reg  <= coord ? y0 : r0;
        end else begin
            if (t >= {1'b0, den_reg}) begin
                rem_reg <= 32'(t - {1'b0, den_reg});
                quo_reg <= {quo_reg[DIV_W-2:0], 1'b1};
            end else begin
                rem_reg <= t[31:0];
                quo_reg <= {quo_reg[DIV_W-2:0], 1'b0};
            end
            cnt_reg <= cnt_reg - 6'h01;
            if (cnt_reg == '0)
                busy_reg <= 1'b0;
        end
    end

    logic signed [31:0] interp, inc;
    logic signed [63:0] scaled, stroke_last;
    assign interp      = base_l_reg + (neg_reg ? -quo_reg[31:0] : quo_reg[31:0]);
    assign scaled      = 64'(act_stroke_reg) * 64'(interp);
    assign stroke_last = 64'(act_stroke_reg) * 64'(r_last);
    assign inc         = coord ? y_end : stroke_last[RATIO_SH+31:RATIO_SH];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            std_reg    <= '0;
            corr_reg   <= '0;
            feed_pos   <= '0;
            cam_active <= 1'b0;
            run_reg    <= 1'b0;
        end else begin
            if (wrap_f)
                std_reg <= std_reg + inc;
            else if (wrap_b)
                std_reg <= std_reg - inc;
            if (p_st && !p_pv)
                corr_reg <= probe_ref_reg - pos_reg;
            if (busy_reg && cnt_reg == '0)
                feed_pos <= std_reg + corr_reg + (coord_l_reg ? interp
                            : scaled[RATIO_SH+31:RATIO_SH]);
            cam_active <= run;
            run_reg    <= run;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_cmd_rise;
        ctrl_reg.cmd && !cmd_q_reg;
    endsequence
    sequence s_tmp_wr;
        we && ap_reg.a == A_TTMP && wr_ok;
    endsequence

    property p_cmd_take;
        s_cmd_rise |=> act_cam_reg == $past(ctrl_reg.use_cd ? cdno_reg : camsel_reg)
                       && act_stroke_reg == $past(stroke_reg);
    endproperty
    a_cmd_take: assert property (p_cmd_take) else $error("cam select not taken");
    property p_cmd_hold;
        !cmd_rise |=> $stable(act_cam_reg) && $stable(act_stroke_reg);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("cam select moved");
    property p_tmp;
        s_tmp_wr |=> ram[$past(taddr_reg)] == $past(hwdata);
    endproperty
    a_tmp: assert property (p_tmp) else $error("temporary write lost");
    property p_perm;
        we && ap_reg.a == A_TPERM && wr_ok |=> nv[$past(taddr_reg)] == $past(hwdata)
            && ram[$past(taddr_reg)] == $past(ram[taddr_reg]);
    endproperty
    a_perm: assert property (p_perm) else $error("permanent write wrong");
    property p_copy;
        ld_state_reg == LD_COPY |=> ram[$past(ld_idx_reg)] == $past(nv[ld_idx_reg]);
    endproperty
    a_copy: assert property (p_copy) else $error("power-up copy wrong");
    property p_init;
        init_hit |=> ld_state_reg == LD_ERASE ##1 ld_idx_reg == 11'h001;
    endproperty
    a_init: assert property (p_init) else $error("init key ignored");
    property p_run;
        !run |=> $stable(pos_reg);
    endproperty
    a_run: assert property (p_run) else $error("axis moved while cam off");
    property p_wrap;
        wrap_f |=> pos_reg == '0 && idx_reg == '0 && std_reg == $past(std_reg) + $past(inc);
    endproperty
    a_wrap: assert property (p_wrap) else $error("cycle wrap wrong");
    property p_probe;
        p_st && !p_pv |=> corr_reg == $past(probe_ref_reg - pos_reg);
    endproperty
    a_probe: assert property (p_probe) else $error("probe correction wrong");
    property p_step;
        run && !ctrl_reg.src_servo && enc_step && enc_fwd && !wrap_f
            |=> pos_reg == $past(pos_reg) + 32'h0000_0001;
    endproperty
    a_step: assert property (p_step) else $error("encoder step lost");
endmodule : cam_profile_store_select

// ---- dv/enc_probe_model.sv ----
// Partner model: quadrature sync encoder and touch probe
module enc_probe_model (
    input  wire logic hclk,
    output logic      enc_a,
    output logic      enc_b,
    output logic      probe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'b00;
    logic       pr = 1'b0;
    assign {enc_a, enc_b} = ph;
    assign probe_in       = pr;
    // ****************************************
    // Stimulus tasks
    // ****************************************
    // A leads B forward; 4 cycles a step beats the 3-FF filter
    task automatic move(input int n, input logic fwd);
        repeat (n) begin
            repeat (4) @(posedge hclk);
            ph <= fwd ? {~ph[0], ph[1]} : {ph[0], ~ph[1]};
        end
        repeat (8) @(posedge hclk);
    endtask : move
    task automatic touch();
        @(posedge hclk);
        pr <= 1'b1;
        repeat (8) @(posedge hclk);
        pr <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask : touch
endmodule : enc_probe_model

// ---- dv/cam_profile_store_select_tb.sv ----
// Testbench: bus, source select, encoder, probe and store checks
module cam_profile_store_select_tb import cam_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic        servo_step = 0, servo_dir = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, feed_pos, q;
    logic        hreadyout, hresp, cam_active, enc_a, enc_b, probe_in;
    int          mismatches = 0, checks = 0, pos = 0, n, r, c, s;
    always #4 hclk = ~hclk;
    enc_probe_model i_enc (.hclk(hclk), .enc_a(enc_a), .enc_b(enc_b),
        .probe_in(probe_in));
    cam_profile_store_select i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .enc_a(enc_a), .enc_b(enc_b), .probe_in(probe_in),
        .servo_step(servo_step), .servo_dir(servo_dir),
        .feed_pos(feed_pos), .cam_active(cam_active));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic test_done();
        $display("Counts: %0d mismatches, %0d checks", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0000_00, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), e, q);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        n = $urandom(32'he52a_8b7e);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(A_CTRL, 32'h0000_0000);
        rd(A_CYCLEN, CYCLEN_RST);
        rd(A_NCOORD, 32'h0000_0002);
        rd(8'hC0, 32'h0000_0000);
        repeat (2100) @(posedge hclk);
        xfer(1'b0, A_STAT, 32'h0000_0000);
        chk("loaded", 32'h1, {31'h0, q[ST_LOADED]});
        wr(A_FUNC, 32'h0000_0001);
        wr(A_OPMODE, 32'h0000_0005);
        repeat (3) @(posedge hclk);
        chk("cam_active", 32'h0, {31'h0, cam_active});
        wr(A_OPMODE, {28'h0, OPMODE_PT});
        repeat (3) @(posedge hclk);
        chk("cam_active", 32'h1, {31'h0, cam_active});
        n = $urandom_range(40, 5);
        i_enc.move(n, 1'b1);
        pos += n;
        rd(A_CPOS, pos);
        n = $urandom_range(4, 1);
        i_enc.move(n, 1'b0);
        pos -= n;
        rd(A_CPOS, pos);
        r = $urandom_range(1000, 0);
        wr(A_PROBE, r);
        i_enc.touch();
        // Correction lands in the feed output; the cycle position keeps its value
        c = r - pos;
        repeat (60) @(posedge hclk);
        rd(A_CPOS, pos);
        chk("feed_pos", c, feed_pos);
        wr(A_CTRL, 32'h0000_0001);
        i_enc.move(5, 1'b1);
        rd(A_CPOS, pos);
        n = $urandom_range(20, 1);
        repeat (n) begin
            @(posedge hclk);
            servo_step <= 1'b1; servo_dir <= 1'b1;
            @(posedge hclk);
            servo_step <= 1'b0;
        end
        repeat (4) @(posedge hclk);
        pos += n;
        rd(A_CPOS, pos);
        // Table write with servo on must be refused and flagged
        wr(A_CTRL, 32'h0000_0041);
        wr(A_TTMP, 32'h0000_1234);
        xfer(1'b0, A_STAT, 32'h0000_0000);
        chk("warn", 32'h1, {31'h0, q[ST_WARN]});
        wr(A_CTRL, 32'h0000_0001);
        wr(A_INIT, {16'h0000, INIT_KEY});
        repeat (2100) @(posedge hclk);
        xfer(1'b0, A_STAT, 32'h0000_0000);
        chk("warn", 32'h0, {31'h0, q[ST_WARN]});
        s = 2 * $urandom_range(5000, 1);
        wr(A_CDNO, 32'h0000_0002);
        wr(A_CAMSEL, 32'h0000_0001);
        wr(A_STROKE, s);
        wr(A_CTRL, 32'h0000_0007);
        xfer(1'b0, A_STAT, 32'h0000_0000);
        chk("act_cam", 32'h2, {28'h0, q[7:4]});
        wr(A_CTRL, 32'h0000_0001);
        wr(A_CTRL, 32'h0000_0003);
        xfer(1'b0, A_STAT, 32'h0000_0000);
        chk("act_cam", 32'h1, {28'h0, q[7:4]});
        // Storage writes kept few, far under the endurance limit
        wr(A_TADDR, 32'h0000_0000);
        repeat (256) wr(A_TPERM, 32'h0000_8000);
        repeat (110) @(posedge hclk);
        chk("feed_pos", c, feed_pos);
        wr(A_TADDR, 32'h0000_0000);
        repeat (256) wr(A_TTMP, RATIO_FULL);
        repeat (110) @(posedge hclk);
        chk("feed_pos", c + s, feed_pos);
        // Power cycle: RAM reloads from storage, temporary data is gone
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("feed_pos", 32'h0, feed_pos);
        chk("cam_active", 32'h0, {31'h0, cam_active});
        xfer(1'b0, A_STAT, 32'h0000_0000);
        chk("loaded", 32'h0, {31'h0, q[ST_LOADED]});
        repeat (2100) @(posedge hclk);
        wr(A_FUNC, 32'h0000_0001);
        wr(A_OPMODE, {28'h0, OPMODE_PT});
        wr(A_CAMSEL, 32'h0000_0001);
        wr(A_STROKE, s);
        wr(A_CTRL, 32'h0000_0002);
        repeat (110) @(posedge hclk);
        chk("feed_pos", s / 2, feed_pos);
        chk("hresp", 32'h0, {31'h0, hresp});
        test_done();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        test_done();
    end
endmodule : cam_profile_store_select_tb
